// [rtl/rx_lock_ctrl_regs.svh]
/*
 * Register map, field positions, reset values and limits of the receive lock-source control block.
 * Assumes inclusion by bare name from the design modules and the testbench.
 */
`ifndef RX_LOCK_CTRL_REGS_SVH
`define RX_LOCK_CTRL_REGS_SVH

// Word offsets on the Avalon-MM slave (byte address = word offset * 4)
`define REG_CTRL_OFS 4'h0
`define REG_TRIP_OFS 4'h1
`define REG_STATUS_OFS 4'h2
`define REG_IRQ_STAT_OFS 4'h3
`define REG_IRQ_MASK_OFS 4'h4

// CTRL: receiver enable per channel in [3:0]
`define CTRL_RX_EN_LSB 0
`define CTRL_RESET 4'hf

// TRIP: two bits of level trip select per channel, channel n at [2n+1:2n]
`define TRIP_RESET 8'h00

// STATUS: live channel state
`define STAT_FAULT_LSB 0
`define STAT_TRACK_LSB 4
`define STAT_DENS_LSB 8
`define STAT_LEVEL_LSB 12

// IRQ status and mask: fault raised [3:0], lock source changed [7:4]
`define IRQ_FAULT_LSB 0
`define IRQ_TRACK_LSB 4
`define IRQ_RESET 8'h00

// Transition density limit: bits without a transition before the stream is invalid
`define DENSITY_RUN_LIMIT 6'h3c

// Serial rate ranges in MBaud
`define RATE_LOW_MIN_MBAUD 195
`define RATE_MID_MIN_MBAUD 400
`define RATE_HIGH_MIN_MBAUD 800
`define RATE_HIGH_MAX_MBAUD 1500

`define READ_ZERO 32'h0000_0000

`endif

// [rtl/rx_lock_ctrl_pkg.sv]
/*
 * Types shared by the receive lock-source control modules.
 * Assumes the register header sits on the include path.
 */
package rx_lock_ctrl_pkg;
    typedef enum logic [1:0] {
        RATE_LOW = 2'h0,
        RATE_MID = 2'h1,
        RATE_HIGH = 2'h2
    } rate_range_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h1,
        BUS_ACK = 2'h2
    } bus_state_t;
endpackage : rx_lock_ctrl_pkg

// [rtl/rx_lock_channel.sv]
/*
 * One receive channel: lock source choice, input and loopback steering, rate range, link fault.
 * Assumes serial inputs are sampled one bit per clock and are synchronous to sys_clk_in.
 */
`timescale 1ns/1ps
`include "rx_lock_ctrl_regs.svh"

module rx_lock_channel
    import rx_lock_ctrl_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic level_density_check_en_in,
    input wire logic use_local_clock_n_in,
    input wire logic rx_input_select_in,
    input wire logic serial_loopback_en_in,
    input wire logic [1:0] rate_range_select_in,
    input wire logic [1:0] level_trip_select_in,
    input wire logic rx_enable_in,
    input wire logic primary_serial_in,
    input wire logic secondary_serial_in,
    input wire logic tx_serial_in,
    input wire logic [1:0] signal_amplitude_in,
    input wire logic rate_in_range_in,
    input wire logic refclk_present_in,
    output logic cdr_serial_out,
    output logic track_serial_data_out,
    output logic serial_drive_out,
    output logic link_fault_n_out,
    output rate_range_t pll_range_out,
    output logic density_ok_out,
    output logic level_ok_out
);
    logic cdr_bit;
    logic prev_bit_q;
    logic [5:0] run_len_q;
    logic [5:0] run_len_d;
    logic density_ok;
    logic level_ok;
    logic data_ok;

    // Loopback wins over the external input pair
    always_comb begin
        if (serial_loopback_en_in) begin
            cdr_bit = tx_serial_in;
        end else if (rx_input_select_in) begin
            cdr_bit = primary_serial_in;
        end else begin
            cdr_bit = secondary_serial_in;
        end
    end

    // Run length saturates so a dead line never wraps back to valid
    always_comb begin
        if (cdr_bit != prev_bit_q) begin
            run_len_d = 6'h01;
        end else if (run_len_q < `DENSITY_RUN_LIMIT) begin
            run_len_d = run_len_q + 6'h01;
        end else begin
            run_len_d = run_len_q;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prev_bit_q <= 1'b0;
            run_len_q <= 6'h00;
        end else begin
            prev_bit_q <= cdr_bit;
            run_len_q <= run_len_d;
        end
    end

    assign density_ok = (run_len_q < `DENSITY_RUN_LIMIT);
    assign level_ok = (signal_amplitude_in >= level_trip_select_in);

    always_comb begin
        if (level_density_check_en_in) begin
            data_ok = rate_in_range_in & level_ok & density_ok;
        end else begin
            data_ok = rate_in_range_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cdr_serial_out <= 1'b0;
            track_serial_data_out <= 1'b0;
            serial_drive_out <= 1'b1;
            link_fault_n_out <= 1'b0;
            pll_range_out <= RATE_MID;
            density_ok_out <= 1'b0;
            level_ok_out <= 1'b0;
        end else begin
            cdr_serial_out <= cdr_bit;
            track_serial_data_out <= use_local_clock_n_in & data_ok;
            serial_drive_out <= serial_loopback_en_in | tx_serial_in;
            link_fault_n_out <= rate_in_range_in & level_ok & density_ok & rx_enable_in
                & use_local_clock_n_in & refclk_present_in;
            // A floating pin that reads as the unused code is taken as mid
            pll_range_out <= (rate_range_select_in == RATE_LOW) ? RATE_LOW
                : (rate_range_select_in == RATE_HIGH) ? RATE_HIGH : RATE_MID;
            density_ok_out <= density_ok;
            level_ok_out <= level_ok;
        end
    end
endmodule : rx_lock_channel

// [rtl/rx_lock_source_and_loopback_ctrl.sv]
/*
 * Top of the four-channel receive lock-source and loopback control with an Avalon-MM register slave.
 * Assumes static board pins synchronous to sys_clk_in and a master that honours waitrequest.
 */
`timescale 1ns/1ps
`include "rx_lock_ctrl_regs.svh"

module rx_lock_source_and_loopback_ctrl
    import rx_lock_ctrl_pkg::*;
#(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    input wire logic level_density_check_en_in,
    input wire logic [CHANNELS-1:0] use_local_clock_n_in,
    input wire logic [CHANNELS-1:0] rx_input_select_in,
    input wire logic [CHANNELS-1:0] serial_loopback_en_in,
    input wire logic [2*CHANNELS-1:0] rate_range_select_in,
    input wire logic [CHANNELS-1:0] primary_serial_in,
    input wire logic [CHANNELS-1:0] secondary_serial_in,
    input wire logic [CHANNELS-1:0] tx_serial_in,
    input wire logic [2*CHANNELS-1:0] signal_amplitude_in,
    input wire logic [CHANNELS-1:0] rate_in_range_in,
    input wire logic [CHANNELS-1:0] refclk_present_in,
    output logic [CHANNELS-1:0] cdr_serial_out,
    output logic [CHANNELS-1:0] track_serial_data_out,
    output logic [CHANNELS-1:0] serial_drive_out,
    output logic [CHANNELS-1:0] link_fault_n_out,
    output logic [2*CHANNELS-1:0] pll_range_out
);
    bus_state_t bus_state_q;
    bus_state_t bus_state_d;
    logic bus_req;
    logic bus_accept;
    logic wr_accept;
    logic rd_accept;

    logic [CHANNELS-1:0] rx_enable_q;
    logic [2*CHANNELS-1:0] level_trip_select_q;
    logic [2*CHANNELS-1:0] irq_stat_q;
    logic [2*CHANNELS-1:0] irq_stat_d;
    logic [2*CHANNELS-1:0] irq_mask_q;
    logic [2*CHANNELS-1:0] irq_event;
    logic irq_clear;
    logic [31:0] read_mux;

    logic [CHANNELS-1:0] ch_fault_n;
    logic [CHANNELS-1:0] ch_track;
    logic [CHANNELS-1:0] ch_dens_ok;
    logic [CHANNELS-1:0] ch_level_ok;
    logic [CHANNELS-1:0] fault_n_prev_q;
    logic [CHANNELS-1:0] track_prev_q;
    logic events_armed_q;

    // Bus handshake: one wait cycle, then answer with waitrequest low
    assign bus_req = avs_read_in | avs_write_in;

    always_comb begin
        bus_state_d = bus_state_q;
        unique case (bus_state_q)
            BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_d = BUS_ACK;
                end
            end
            BUS_ACK: begin
                bus_state_d = BUS_IDLE;
            end
            default: begin
                bus_state_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_state_q <= BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !(bus_state_q == BUS_IDLE && bus_req);
        end
    end

    // The master samples waitrequest low in BUS_ACK; that edge commits the access
    assign bus_accept = (bus_state_q == BUS_ACK) && bus_req;
    assign wr_accept = bus_accept && avs_write_in;
    assign rd_accept = bus_accept && avs_read_in;

    // Read data is staged one cycle early so it stands when waitrequest drops
    always_comb begin
        read_mux = `READ_ZERO;
        unique case (avs_address_in)
            `REG_CTRL_OFS: begin
                read_mux[`CTRL_RX_EN_LSB +: CHANNELS] = rx_enable_q;
            end
            `REG_TRIP_OFS: begin
                read_mux[2*CHANNELS-1:0] = level_trip_select_q;
            end
            `REG_STATUS_OFS: begin
                read_mux[`STAT_FAULT_LSB +: CHANNELS] = ~ch_fault_n;
                read_mux[`STAT_TRACK_LSB +: CHANNELS] = ch_track;
                read_mux[`STAT_DENS_LSB +: CHANNELS] = ch_dens_ok;
                read_mux[`STAT_LEVEL_LSB +: CHANNELS] = ch_level_ok;
            end
            `REG_IRQ_STAT_OFS: begin
                // Events landing at the capture edge are shown, else the clear would lose them
                read_mux[2*CHANNELS-1:0] = irq_stat_q | irq_event;
            end
            `REG_IRQ_MASK_OFS: begin
                read_mux[2*CHANNELS-1:0] = irq_mask_q;
            end
            default: begin
                read_mux = `READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            avs_readdata_out <= `READ_ZERO;
        end else if (bus_state_q == BUS_IDLE && avs_read_in) begin
            avs_readdata_out <= read_mux;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rx_enable_q <= `CTRL_RESET;
        end else if (wr_accept && avs_address_in == `REG_CTRL_OFS) begin
            rx_enable_q <= avs_writedata_in[`CTRL_RX_EN_LSB +: CHANNELS];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            level_trip_select_q <= `TRIP_RESET;
        end else if (wr_accept && avs_address_in == `REG_TRIP_OFS) begin
            level_trip_select_q <= avs_writedata_in[2*CHANNELS-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_mask_q <= `IRQ_RESET;
        end else if (wr_accept && avs_address_in == `REG_IRQ_MASK_OFS) begin
            irq_mask_q <= avs_writedata_in[2*CHANNELS-1:0];
        end
    end

    // Per-channel copies share nothing but clock, reset and the global check enable
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
            rate_range_t ch_range;

            rx_lock_channel u_channel (
                .sys_clk_in(sys_clk_in),
                .nrst_in(nrst_in),
                .level_density_check_en_in(level_density_check_en_in),
                .use_local_clock_n_in(use_local_clock_n_in[ch]),
                .rx_input_select_in(rx_input_select_in[ch]),
                .serial_loopback_en_in(serial_loopback_en_in[ch]),
                .rate_range_select_in(rate_range_select_in[2*ch +: 2]),
                .level_trip_select_in(level_trip_select_q[2*ch +: 2]),
                .rx_enable_in(rx_enable_q[ch]),
                .primary_serial_in(primary_serial_in[ch]),
                .secondary_serial_in(secondary_serial_in[ch]),
                .tx_serial_in(tx_serial_in[ch]),
                .signal_amplitude_in(signal_amplitude_in[2*ch +: 2]),
                .rate_in_range_in(rate_in_range_in[ch]),
                .refclk_present_in(refclk_present_in[ch]),
                .cdr_serial_out(cdr_serial_out[ch]),
                .track_serial_data_out(ch_track[ch]),
                .serial_drive_out(serial_drive_out[ch]),
                .link_fault_n_out(ch_fault_n[ch]),
                .pll_range_out(ch_range),
                .density_ok_out(ch_dens_ok[ch]),
                .level_ok_out(ch_level_ok[ch])
            );

            assign pll_range_out[2*ch +: 2] = ch_range;
            assign track_serial_data_out[ch] = ch_track[ch];
            assign link_fault_n_out[ch] = ch_fault_n[ch];
        end
    endgenerate

    // Edge history; first cycle after reset is skipped so reset values raise no event
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fault_n_prev_q <= {CHANNELS{1'b1}};
            track_prev_q <= {CHANNELS{1'b0}};
            events_armed_q <= 1'b0;
        end else begin
            fault_n_prev_q <= ch_fault_n;
            track_prev_q <= ch_track;
            events_armed_q <= 1'b1;
        end
    end

    assign irq_event[`IRQ_FAULT_LSB +: CHANNELS] = {CHANNELS{events_armed_q}} & fault_n_prev_q & ~ch_fault_n;
    assign irq_event[`IRQ_TRACK_LSB +: CHANNELS] = {CHANNELS{events_armed_q}} & (track_prev_q ^ ch_track);

    // Read of the status clears it; an event in the same cycle still lands
    assign irq_clear = rd_accept && (avs_address_in == `REG_IRQ_STAT_OFS);

    always_comb begin
        irq_stat_d = irq_clear ? `IRQ_RESET : irq_stat_q;
        irq_stat_d = irq_stat_d | irq_event;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_stat_q <= `IRQ_RESET;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_d & irq_mask_q);
        end
    end
endmodule : rx_lock_source_and_loopback_ctrl

// [dv/rx_lock_ctrl_props.sv]
/* Checker for the lock-source control pins of all channels.
   Assumes binding to the top module; sees only its ports. */
`timescale 1ns/1ps
module rx_lock_ctrl_props #(
    parameter int CHANNELS = 4
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic level_density_check_en_in,
    input wire logic [CHANNELS-1:0] use_local_clock_n_in,
    input wire logic [CHANNELS-1:0] rx_input_select_in,
    input wire logic [CHANNELS-1:0] serial_loopback_en_in,
    input wire logic [2*CHANNELS-1:0] rate_range_select_in,
    input wire logic [CHANNELS-1:0] primary_serial_in,
    input wire logic [CHANNELS-1:0] secondary_serial_in,
    input wire logic [CHANNELS-1:0] tx_serial_in,
    input wire logic [CHANNELS-1:0] rate_in_range_in,
    input wire logic [CHANNELS-1:0] refclk_present_in,
    input wire logic [CHANNELS-1:0] cdr_serial_out,
    input wire logic [CHANNELS-1:0] track_serial_data_out,
    input wire logic [CHANNELS-1:0] link_fault_n_out,
    input wire logic [CHANNELS-1:0] serial_drive_out,
    input wire logic [2*CHANNELS-1:0] pll_range_out
);
    logic [CHANNELS-1:0] lp_q, ext_q, tx_q, ulc_q, rng_q, ref_q;
    logic [2*CHANNELS-1:0] rm_q;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    // Inputs one edge back, to line up with registered outputs
    always_ff @(posedge sys_clk_in) begin
        lp_q <= serial_loopback_en_in;
        ext_q <= (rx_input_select_in & primary_serial_in) | (~rx_input_select_in & secondary_serial_in);
        tx_q <= tx_serial_in;
        ulc_q <= use_local_clock_n_in;
        rng_q <= rate_in_range_in;
        ref_q <= refclk_present_in;
        for (int i = 0; i < CHANNELS; i++) begin
            rm_q[2*i+:2] <= (rate_range_select_in[2*i+:2] == 2'h3) ? 2'h1 : rate_range_select_in[2*i+:2];
        end
    end
    a_drive_one_loop: assert property (1 |=> serial_drive_out == (tx_q | lp_q))
        else $error("serial drive wrong");
    a_cdr_input_steer: assert property (1 |=> cdr_serial_out == ((lp_q & tx_q) | (~lp_q & ext_q)))
        else $error("cdr input wrong");
    a_local_ref_lock: assert property (1 |=> (track_serial_data_out & ~ulc_q) == '0)
        else $error("tracking data while local clock forced");
    a_local_fault_low: assert property (1 |=> (link_fault_n_out & ~ulc_q) == '0)
        else $error("no fault while local clock forced");
    a_check_off_range: assert property (!level_density_check_en_in |=>
        track_serial_data_out == (ulc_q & rng_q)) else $error("track not from range alone");
    a_detect_out_ref: assert property (level_density_check_en_in |=>
        (track_serial_data_out & ~rng_q) == '0) else $error("tracking data out of range");
    a_fault_or_causes: assert property (1 |=> (link_fault_n_out & ~(ulc_q & rng_q & ref_q)) == '0)
        else $error("fault cause missed");
    a_rate_range_map: assert property (1 |=> pll_range_out == rm_q)
        else $error("pll range wrong");
endmodule : rx_lock_ctrl_props

bind rx_lock_source_and_loopback_ctrl rx_lock_ctrl_props #(.CHANNELS(CHANNELS)) props_u (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .level_density_check_en_in(level_density_check_en_in),
    .use_local_clock_n_in(use_local_clock_n_in), .rx_input_select_in(rx_input_select_in),
    .serial_loopback_en_in(serial_loopback_en_in), .rate_range_select_in(rate_range_select_in),
    .primary_serial_in(primary_serial_in), .secondary_serial_in(secondary_serial_in),
    .tx_serial_in(tx_serial_in), .rate_in_range_in(rate_in_range_in), .refclk_present_in(refclk_present_in),
    .cdr_serial_out(cdr_serial_out), .track_serial_data_out(track_serial_data_out),
    .link_fault_n_out(link_fault_n_out), .serial_drive_out(serial_drive_out), .pll_range_out(pll_range_out));

// [dv/remote_serial_tx.sv]
/* Far-end serial transmitter model, one bit per clock on each line.
   Assumes sys_clk_in; hold_in freezes all lines to mimic a dead link. */
`timescale 1ns/1ps
module remote_serial_tx (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic hold_in,
    output logic [3:0] primary_out,
    output logic [3:0] secondary_out,
    output logic [3:0] tx_out
);
    logic [2:0] cnt_q;
    // Frozen count gives no transitions at all
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_q <= 3'h0;
        end else if (!hold_in) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    // Distinct rates per line, so a wrong steering choice shows
    assign primary_out = {4{cnt_q[0]}} ^ 4'h5;
    assign secondary_out = {4{cnt_q[1]}} ^ 4'h3;
    assign tx_out = {4{cnt_q[2]}} ^ 4'h6;
endmodule : remote_serial_tx

// [dv/rx_lock_source_and_loopback_ctrl_tb.sv]
/* Self-checking bench: Avalon-MM register tasks and pin scenarios.
   Assumes design, checker and far-end model compiled first. */
`timescale 1ns/1ps
`include "rx_lock_ctrl_regs.svh"
module rx_lock_source_and_loopback_ctrl_tb;
    logic sys_clk_in, nrst_in, avs_read_in, avs_write_in, irq_out, avs_waitrequest_out, hold, chk_en, ok;
    logic [3:0] avs_address_in, ulc, insel, lpen, pri, sec, tx, rng, refp, cdr, trk, drv, lfn;
    logic [7:0] rsel, amp, prng;
    logic [31:0] avs_writedata_in, avs_readdata_out, rd;
    int miscompares = 0;
    int n_tests = 0;
    rx_lock_source_and_loopback_ctrl dut_u (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
        .level_density_check_en_in(chk_en), .use_local_clock_n_in(ulc), .rx_input_select_in(insel),
        .serial_loopback_en_in(lpen), .rate_range_select_in(rsel), .primary_serial_in(pri),
        .secondary_serial_in(sec), .tx_serial_in(tx), .signal_amplitude_in(amp), .rate_in_range_in(rng),
        .refclk_present_in(refp), .cdr_serial_out(cdr), .track_serial_data_out(trk),
        .serial_drive_out(drv), .link_fault_n_out(lfn), .pll_range_out(prng));
    remote_serial_tx far_u (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hold_in(hold),
        .primary_out(pri), .secondary_out(sec), .tx_out(tx));
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    task automatic tally_and_finish;
        if (miscompares == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk
    // One access; holds everything until the rising edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address_in <= adr;
        avs_writedata_in <= wd;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        ok = (avs_waitrequest_out === 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge sys_clk_in);
        if (!ok) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : bus
    task automatic rchk(input logic [3:0] adr, input logic [31:0] exp, input string msg);
        bus(1'b0, adr, 32'h0000_0000);
        chk(rd, exp, msg);
    endtask : rchk
    task automatic settle;
        repeat (3) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask : settle
    // v = {local_n, check, range ok, refclk, amplitude[1:0], track, fault_n}
    task automatic pins(input logic [7:0] v, input string msg);
        {ulc[0], chk_en, rng[0], refp[0], amp[1:0]} <= v[7:2];
        settle();
        chk({30'h0, trk[0], lfn[0]}, {30'h0, v[1:0]}, msg);
        @(posedge sys_clk_in);
    endtask : pins
    initial begin
        {nrst_in, avs_read_in, avs_write_in, hold} = 4'h0;
        chk_en = 1'b1;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0000_0000;
        {ulc, insel, lpen, rng, refp} = 20'hf_53ff;
        rsel = 8'h09;
        amp = 8'hff;
        repeat (10) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        @(posedge sys_clk_in);
        rchk(`REG_CTRL_OFS, 32'h0000_000f, "ctrl reset");
        rchk(`REG_TRIP_OFS, 32'h0000_0000, "trip reset");
        rchk(`REG_IRQ_MASK_OFS, 32'h0000_0000, "mask reset");
        bus(1'b1, 4'h9, 32'hffff_ffff);
        rchk(4'h9, 32'h0000_0000, "unmapped read");
        pins(8'h7c, "local clock");
        pins(8'hff, "nominal");
        pins(8'hdc, "range out");
        pins(8'h9c, "check off range out");
        pins(8'hee, "no refclk");
        bus(1'b1, `REG_TRIP_OFS, 32'h0000_0003);
        pins(8'hf8, "below trip");
        pins(8'hba, "check off below trip");
        pins(8'hff, "at trip");
        bus(1'b1, `REG_CTRL_OFS, 32'h0000_000e);
        settle();
        chk({28'h0, lfn}, 32'h0000_000e, "rx disabled fault");
        @(posedge sys_clk_in);
        bus(1'b1, `REG_CTRL_OFS, 32'h0000_000f);
        for (int i = 0; i < 4; i++) begin
            rsel[1:0] <= i[1:0];
            settle();
            chk({24'h0, prng}, {24'h0, 6'h2, (i == 3) ? 2'h1 : i[1:0]}, "rate range");
            @(posedge sys_clk_in);
        end
        {insel, lpen} <= 8'hac;
        // Frozen far end so the expected bits are stable when compared
        hold <= 1'b1;
        settle();
        chk({24'h0, cdr, drv}, {24'h0, tx[3:2], pri[1], sec[0], 2'h3, tx[1:0]}, "steering");
        @(posedge sys_clk_in);
        hold <= 1'b0;
        bus(1'b0, `REG_IRQ_STAT_OFS, 32'h0000_0000);
        bus(1'b1, `REG_IRQ_MASK_OFS, 32'h0000_0001);
        rng[0] <= 1'b0;
        settle();
        chk({31'h0, irq_out}, 32'h0000_0001, "irq on fault");
        @(posedge sys_clk_in);
        rchk(`REG_IRQ_STAT_OFS, 32'h0000_0011, "fault and track events");
        settle();
        chk({31'h0, irq_out}, 32'h0000_0000, "irq after clear");
        @(posedge sys_clk_in);
        rng[0] <= 1'b1;
        settle();
        chk({31'h0, irq_out}, 32'h0000_0000, "masked event");
        @(posedge sys_clk_in);
        rchk(`REG_IRQ_STAT_OFS, 32'h0000_0010, "masked track event");
        // Dead link: 50 bits stay under the limit, 80 exceed it
        hold <= 1'b1;
        repeat (50) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({31'h0, trk[0]}, 32'h0000_0001, "short run");
        repeat (30) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk({30'h0, trk[0], lfn[0]}, 32'h0000_0000, "density loss");
        @(posedge sys_clk_in);
        hold <= 1'b0;
        // First transition may take two counts of the far end, then two register stages
        settle();
        settle();
        chk({31'h0, trk[0]}, 32'h0000_0001, "transitions back");
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        settle();
        chk({24'h0, lfn, drv}, 32'h0000_000f, "reset outputs");
        tally_and_finish();
    end
endmodule : rx_lock_source_and_loopback_ctrl_tb
